/* File: include/twmh_map.svh */
// Constants of the two-wire handshake block: status codes, field widths and bit timing.
`ifndef TWMH_MAP_SVH
`define TWMH_MAP_SVH

// Status codes, upper five bits significant, lower three bits always zero.
`define TWMH_CODE_START 8'h08
`define TWMH_CODE_RSTART 8'h10
`define TWMH_CODE_AW_ACK 8'h18
`define TWMH_CODE_AW_NACK 8'h20
`define TWMH_CODE_DW_ACK 8'h28
`define TWMH_CODE_DW_NACK 8'h30
`define TWMH_CODE_AR_ACK 8'h40
`define TWMH_CODE_AR_NACK 8'h48
`define TWMH_CODE_DR_ACK 8'h50
`define TWMH_CODE_DR_NACK 8'h58
`define TWMH_CODE_S_AW 8'h60
`define TWMH_CODE_S_DR_ACK 8'h80
`define TWMH_CODE_S_DR_NACK 8'h88
`define TWMH_CODE_S_STOP 8'hA0
`define TWMH_CODE_S_AR 8'hA8
`define TWMH_CODE_S_DT_ACK 8'hB8
`define TWMH_CODE_S_DT_NACK 8'hC0
`define TWMH_CODE_IDLE 8'hF8

// Byte size, ack slot index and the start-of-frame counter value.
`define TWMH_BYTE_BITS 8
`define TWMH_ACK_SLOT 4'h8
`define TWMH_CNT_ARM 4'hF

// Quarter bit period of the master clock in ns and in 5 ns reference cycles.
`define TWMH_CLK_NS 5
`define TWMH_QTR_NS 2500
`define TWMH_QTR_CYC ((`TWMH_QTR_NS) / (`TWMH_CLK_NS))
`define TWMH_QTR_W 10

// Transmit FIFO geometry.
`define TWMH_FIFO_W 8
`define TWMH_FIFO_D 8

`endif

/* File: include/twmh_pkg.sv */
// Types shared by the two-wire handshake block.
`default_nettype none

package twmh_pkg;

  // Control word that software writes in one strobe.
  typedef struct packed {
    logic flag_clear;
    logic ack_en;
    logic start_req;
    logic stop_req;
    logic enable;
  } twmh_ctrl_type;

  // Sequencer states, one-hot.
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_MBIT = 6'h02,
    ST_HOLD = 6'h04,
    ST_STOP = 6'h08,
    ST_RSTART = 6'h10,
    ST_SBIT = 6'h20
  } twmh_state_type;

  // Operating role of the interface.
  typedef enum logic [2:0] {
    ROLE_NONE = 3'h0,
    ROLE_MASTER_TRANSMIT = 3'h1,
    ROLE_MASTER_RECEIVE = 3'h2,
    ROLE_SLAVE_TRANSMIT = 3'h3,
    ROLE_SLAVE_RECEIVE = 3'h4
  } twmh_role_type;

endpackage : twmh_pkg

`default_nettype wire

/* File: rtl/twmh_core.sv */
// Byte-level two-wire interface with the software done-flag handshake.
`timescale 1ns/1ps
`default_nettype none
`include "twmh_map.svh"

module twmh_core
  import twmh_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire twmh_ctrl_type i_ctrl,
  input wire logic i_ctrl_wr,
  input wire logic [7:0] i_data,
  input wire logic i_data_valid,
  output logic o_data_ready,
  input wire logic [6:0] i_own_addr,
  input wire logic i_scl_i,
  input wire logic i_sda_i,
  output logic o_scl_o,
  output logic o_scl_oe,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic o_done,
  output logic [7:0] o_status,
  output logic [7:0] o_rx_data,
  output logic o_stop_req,
  output logic o_enable,
  output twmh_role_type o_role
);
  twmh_state_type state;
  logic [1:0] phase;
  logic [`TWMH_QTR_W-1:0] qtr_cnt;
  logic tick;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic is_master;
  logic addr_phase;
  logic addr_now;
  logic rx_dir;
  logic s_tx;
  logic ack_bit;
  logic set_pulse;
  logic stop_done;
  logic ack_en;
  logic start_req;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic bus_busy;
  logic f_valid;
  logic f_pop;
  logic [7:0] f_data;
  logic m_tx;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit bytes wait in the FIFO until the sequencer takes them.
  twmh_fifo #(
    .WIDTH(`TWMH_FIFO_W),
    .DEPTH(`TWMH_FIFO_D)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_valid(i_data_valid),
    .o_ready(o_data_ready),
    .i_data(i_data),
    .o_valid(f_valid),
    .i_ready(f_pop),
    .o_data(f_data)
  );

  // Open-drain pins only ever pull low.
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_scl_o <= 1'b0;
      o_sda_o <= 1'b0;
    end
    else
    begin
      o_scl_o <= 1'b0;
      o_sda_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus lines pass two flops, then a third stage for edge detection.
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], i_scl_i};
      sda_sync <= {sda_sync[0], i_sda_i};
      scl_q <= scl_sync[1];
      sda_q <= sda_sync[1];
    end
  end

  // Line events, and start and stop conditions seen with clock high.
  assign scl_rise = scl_sync[1] && !scl_q;
  assign scl_fall = !scl_sync[1] && scl_q;
  assign start_det = scl_sync[1] && scl_q && sda_q && !sda_sync[1];
  assign stop_det = scl_sync[1] && scl_q && !sda_q && sda_sync[1];
  assign m_tx = addr_now || !rx_dir;

  // Bus occupancy between any start and the following stop.
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      bus_busy <= 1'b0;
    end
    else if (start_det)
    begin
      bus_busy <= 1'b1;
    end
    else if (stop_det)
    begin
      bus_busy <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-bit enable for the master clock; idle outside master states.
  assign tick = (qtr_cnt == `TWMH_QTR_W'(`TWMH_QTR_CYC - 1));

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      qtr_cnt <= '0;
    end
    else if (tick || state == ST_IDLE || state == ST_HOLD || state == ST_SBIT)
    begin
      qtr_cnt <= '0;
    end
    else
    begin
      qtr_cnt <= qtr_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bits written by software; stop request drops after the stop.
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_enable <= 1'b0;
      ack_en <= 1'b0;
      start_req <= 1'b0;
      o_stop_req <= 1'b0;
    end
    else if (i_ctrl_wr)
    begin
      o_enable <= i_ctrl.enable;
      ack_en <= i_ctrl.ack_en;
      start_req <= i_ctrl.start_req;
      o_stop_req <= i_ctrl.stop_req;
    end
    else if (stop_done)
    begin
      o_stop_req <= 1'b0;
    end
  end

  // Done flag: hardware set wins over a software clear in the same cycle.
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_done <= 1'b0;
    end
    else if (set_pulse)
    begin
      o_done <= 1'b1;
    end
    else if (i_ctrl_wr && i_ctrl.flag_clear)
    begin
      o_done <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer for master and slave byte transfers.
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state <= ST_IDLE;
      phase <= 2'h0;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      is_master <= 1'b0;
      addr_phase <= 1'b0;
      addr_now <= 1'b0;
      rx_dir <= 1'b0;
      s_tx <= 1'b0;
      ack_bit <= 1'b1;
      set_pulse <= 1'b0;
      stop_done <= 1'b0;
      f_pop <= 1'b0;
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
      o_status <= `TWMH_CODE_IDLE;
      o_rx_data <= 8'h00;
      o_role <= ROLE_NONE;
    end
    else
    begin
      set_pulse <= 1'b0;
      stop_done <= 1'b0;
      f_pop <= 1'b0;
      if (!o_enable)
      begin
        state <= ST_IDLE;
        is_master <= 1'b0;
        o_scl_oe <= 1'b0;
        o_sda_oe <= 1'b0;
        o_role <= ROLE_NONE;
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            o_scl_oe <= 1'b0;
            o_sda_oe <= 1'b0;
            is_master <= 1'b0;
            if (start_req && !o_done && !bus_busy)
            begin
              state <= ST_RSTART;
              phase <= 2'h2;
            end
            else if (start_det)
            begin
              state <= ST_SBIT;
              bit_cnt <= `TWMH_CNT_ARM;
              addr_now <= 1'b1;
              s_tx <= 1'b0;
            end
          end
          ST_RSTART:
          begin
            if (tick)
            begin
              phase <= phase + 1'b1;
              case (phase)
                2'h0: o_sda_oe <= 1'b0;
                2'h1:
                begin
                  o_scl_oe <= 1'b0;
                  if (!scl_sync[1])
                  begin
                    phase <= phase;
                  end
                end
                2'h2: o_sda_oe <= 1'b1;
                default:
                begin
                  o_scl_oe <= 1'b1;
                  o_status <= is_master ? `TWMH_CODE_RSTART : `TWMH_CODE_START;
                  set_pulse <= 1'b1;
                  is_master <= 1'b1;
                  addr_phase <= 1'b1;
                  state <= ST_HOLD;
                end
              endcase
            end
          end
          ST_MBIT:
          begin
            if (tick)
            begin
              phase <= phase + 1'b1;
              case (phase)
                2'h0:
                begin
                  if (bit_cnt == `TWMH_ACK_SLOT)
                  begin
                    o_sda_oe <= !m_tx && ack_en;
                  end
                  else
                  begin
                    o_sda_oe <= m_tx && !shreg[7];
                  end
                end
                2'h1:
                begin
                  o_scl_oe <= 1'b0;
                  if (!scl_sync[1])
                  begin
                    phase <= phase;
                  end
                end
                2'h2:
                begin
                  if (bit_cnt == `TWMH_ACK_SLOT)
                  begin
                    ack_bit <= sda_sync[1];
                  end
                  else
                  begin
                    shreg <= {shreg[6:0], sda_sync[1]};
                  end
                end
                default:
                begin
                  o_scl_oe <= 1'b1;
                  bit_cnt <= bit_cnt + 1'b1;
                  if (bit_cnt == `TWMH_ACK_SLOT)
                  begin
                    o_sda_oe <= 1'b0;
                    set_pulse <= 1'b1;
                    state <= ST_HOLD;
                    if (addr_now)
                    begin
                      o_role <= rx_dir ? ROLE_MASTER_RECEIVE : ROLE_MASTER_TRANSMIT;
                      o_status <= rx_dir ? (ack_bit ? `TWMH_CODE_AR_NACK : `TWMH_CODE_AR_ACK)
                                         : (ack_bit ? `TWMH_CODE_AW_NACK : `TWMH_CODE_AW_ACK);
                    end
                    else if (!rx_dir)
                    begin
                      o_status <= ack_bit ? `TWMH_CODE_DW_NACK : `TWMH_CODE_DW_ACK;
                    end
                    else
                    begin
                      o_rx_data <= shreg;
                      o_status <= ack_en ? `TWMH_CODE_DR_ACK : `TWMH_CODE_DR_NACK;
                    end
                  end
                end
              endcase
            end
          end
          ST_HOLD:
          begin
            o_scl_oe <= 1'b1;
            if (!is_master && stop_det)
            begin
              o_status <= `TWMH_CODE_S_STOP;
              set_pulse <= 1'b1;
              o_sda_oe <= 1'b0;
              o_scl_oe <= 1'b0;
              state <= ST_IDLE;
            end
            else if (!o_done && !set_pulse)
            begin
              if (is_master && o_stop_req)
              begin
                state <= ST_STOP;
                phase <= 2'h0;
              end
              else if (is_master && start_req)
              begin
                state <= ST_RSTART;
                phase <= 2'h0;
              end
              else if (is_master && !(addr_phase || !rx_dir))
              begin
                state <= ST_MBIT;
                phase <= 2'h0;
                bit_cnt <= 4'h0;
                addr_now <= 1'b0;
              end
              else if (f_valid && !f_pop)
              begin
                f_pop <= 1'b1;
                shreg <= f_data;
                bit_cnt <= 4'h0;
                if (is_master)
                begin
                  state <= ST_MBIT;
                  phase <= 2'h0;
                  addr_now <= addr_phase;
                  addr_phase <= 1'b0;
                  if (addr_phase)
                  begin
                    rx_dir <= f_data[0];
                  end
                end
                else
                begin
                  state <= ST_SBIT;
                  o_scl_oe <= 1'b0;
                  o_sda_oe <= s_tx && !f_data[7];
                end
              end
              else if (!is_master && !s_tx)
              begin
                state <= ST_SBIT;
                o_scl_oe <= 1'b0;
              end
            end
          end
          ST_STOP:
          begin
            if (tick)
            begin
              phase <= phase + 1'b1;
              case (phase)
                2'h0: o_sda_oe <= 1'b1;
                2'h1:
                begin
                  o_scl_oe <= 1'b0;
                  if (!scl_sync[1])
                  begin
                    phase <= phase;
                  end
                end
                default:
                begin
                  o_sda_oe <= 1'b0;
                  stop_done <= 1'b1;
                  o_role <= ROLE_NONE;
                  state <= ST_IDLE;
                end
              endcase
            end
          end
          ST_SBIT:
          begin
            if (stop_det)
            begin
              o_sda_oe <= 1'b0;
              o_status <= `TWMH_CODE_S_STOP;
              set_pulse <= !addr_now;
              state <= ST_IDLE;
            end
            else if (start_det)
            begin
              bit_cnt <= `TWMH_CNT_ARM;
              addr_now <= 1'b1;
              s_tx <= 1'b0;
            end
            else if (scl_rise)
            begin
              if (bit_cnt == `TWMH_ACK_SLOT)
              begin
                ack_bit <= sda_sync[1];
              end
              else if (bit_cnt < `TWMH_ACK_SLOT && !s_tx)
              begin
                shreg <= {shreg[6:0], sda_sync[1]};
              end
            end
            else if (scl_fall)
            begin
              bit_cnt <= bit_cnt + 1'b1;
              if (bit_cnt < 4'h7 || bit_cnt == `TWMH_CNT_ARM)
              begin
                if (s_tx)
                begin
                  shreg <= {shreg[6:0], 1'b0};
                  o_sda_oe <= !shreg[6];
                end
              end
              else if (bit_cnt == 4'h7)
              begin
                // Slave acknowledges its own address or data while ack is enabled.
                o_sda_oe <= !s_tx && ack_en && (!addr_now || shreg[7:1] == i_own_addr);
              end
              else if (addr_now && !o_sda_oe)
              begin
                state <= ST_IDLE;
              end
              else
              begin
                o_sda_oe <= 1'b0;
                o_scl_oe <= 1'b1;
                bit_cnt <= 4'h0;
                set_pulse <= 1'b1;
                state <= ST_HOLD;
                addr_now <= 1'b0;
                if (addr_now)
                begin
                  s_tx <= shreg[0];
                  o_role <= shreg[0] ? ROLE_SLAVE_TRANSMIT : ROLE_SLAVE_RECEIVE;
                  o_status <= shreg[0] ? `TWMH_CODE_S_AR : `TWMH_CODE_S_AW;
                end
                else if (s_tx)
                begin
                  o_status <= ack_bit ? `TWMH_CODE_S_DT_NACK : `TWMH_CODE_S_DT_ACK;
                end
                else
                begin
                  o_rx_data <= shreg;
                  o_status <= o_sda_oe ? `TWMH_CODE_S_DR_ACK : `TWMH_CODE_S_DR_NACK;
                end
              end
            end
          end
          default:
          begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the sequencer and the handshake.
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_enter_hold;
    state != ST_HOLD ##1 state == ST_HOLD;
  endsequence

  sequence s_stop_end;
    state == ST_STOP ##1 state == ST_IDLE;
  endsequence

  a_hold_scl_low: assert property (state == ST_HOLD |-> o_scl_oe)
    else $error("clock line released while holding");
  a_hold_sets_flag: assert property (s_enter_hold ##0 o_enable |-> ##1 o_done)
    else $error("done flag not set on entering hold");
  a_flag_suspends: assert property (state == ST_HOLD && o_done && o_enable |=> state == ST_HOLD)
    else $error("transfer resumed while done flag set");
  a_stop_no_flag: assert property (s_stop_end |=> !o_done [*2])
    else $error("done flag set after stop");
  a_stop_autoclear: assert property (s_stop_end ##0 !i_ctrl_wr |=> !o_stop_req)
    else $error("stop request not cleared after stop");
  a_dir_bit: assert property (state == ST_MBIT && addr_now && bit_cnt == 4'h7 && phase == 2'h1 |->
    o_sda_oe == !rx_dir)
    else $error("direction bit driven wrong");
  a_ack_drive: assert property (state == ST_MBIT && !addr_now && rx_dir && bit_cnt == 4'h8 && phase == 2'h2
    |-> o_sda_oe == ack_en)
    else $error("master receive ack slot driven wrong");
  a_byte_length: assert property (state == ST_MBIT |-> bit_cnt <= 4'h8)
    else $error("byte longer than nine slots");
  a_addr_code: assert property (state == ST_MBIT && tick && phase == 2'h3 && bit_cnt == 4'h8 && addr_now
    && !rx_dir && o_enable |=> o_status == (ack_bit ? `TWMH_CODE_AW_NACK : `TWMH_CODE_AW_ACK))
    else $error("wrong address write status");
  a_data_code: assert property (state == ST_MBIT && tick && phase == 2'h3 && bit_cnt == 4'h8 && !addr_now
    && !rx_dir && o_enable |=> o_status == (ack_bit ? `TWMH_CODE_DW_NACK : `TWMH_CODE_DW_ACK))
    else $error("wrong data write status");
  a_clear_one: assert property (o_done && !set_pulse && i_ctrl_wr && !i_ctrl.flag_clear |=> o_done)
    else $error("zero write cleared done flag");

endmodule : twmh_core

`default_nettype wire

/* File: rtl/twmh_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module twmh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW:0] next_count;

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes and the next fill level.
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_valid = (count != '0);
  assign o_data = mem[rd_ptr];
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  ////////////////////////////////////////////////////////////////////////////
  // Storage array, written on push.
  always_ff @(posedge i_ref_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_data;
    end
  end

  // Pointers, fill level and a registered ready that drops when full.
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_ready <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      o_ready <= (next_count < (AW+1)'(DEPTH));
    end
  end

endmodule : twmh_fifo

`default_nettype wire

/* File: verif/twmh_slave.sv */
// Behavioural bus slave that acknowledges on request and keeps the last byte.
`timescale 1ns/1ps
`default_nettype none

module twmh_slave (
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_ack,
  output logic o_sda_oe,
  output logic [7:0] o_byte
);
  int cnt = 0;
  logic [7:0] sh = 8'h00;

  initial o_sda_oe = 1'b0;

  // A falling data line while the clock is high is a start.
  always @(negedge i_sda)
    if (i_scl) cnt = -1;

  // Data bits are taken on the clock rise, first bit is the top one.
  always @(posedge i_scl)
    if (cnt >= 0 && cnt < 8) sh = {sh[6:0], i_sda};

  // The ack slot is driven low after eight bits while i_ack is set, and released after it.
  always @(negedge i_scl)
  begin
    cnt = cnt + 1;
    if (cnt == 8)
    begin
      o_byte = sh;
      o_sda_oe = i_ack;
    end
    else if (cnt == 9)
    begin
      o_sda_oe = 1'b0;
      cnt = 0;
    end
  end
endmodule : twmh_slave

`default_nettype wire

/* File: verif/two_wire_mode_handshake_test.sv */
// Self-checking bench of the two-wire handshake core in the master transmit role.
`timescale 1ns/1ps
`default_nettype none
`include "twmh_map.svh"

module two_wire_mode_handshake_test
  import twmh_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, dv = 1'b0, ack = 1'b1, dq = 1'b0;
  twmh_ctrl_type ctrl = '0;
  logic [7:0] data = 8'h00, d, status, sbyte, rxd;
  logic rdy, scl_oe, sda_oe, s_oe, done, stop_req, scl_o, sda_o, en;
  twmh_role_type role;
  wire logic scl = ~scl_oe;
  wire logic sda = ~(sda_oe | s_oe);
  logic [7:0] q[$];
  int fails = 0, num_checks = 0, cyc = 0;

  twmh_core dut_u (.i_ref_clk(clk), .i_rstn(rstn), .i_ctrl(ctrl), .i_ctrl_wr(wr), .i_data(data),
    .i_data_valid(dv), .o_data_ready(rdy), .i_own_addr(7'h11), .i_scl_i(scl), .i_sda_i(sda),
    .o_scl_o(scl_o), .o_scl_oe(scl_oe), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_done(done), .o_status(status),
    .o_rx_data(rxd), .o_stop_req(stop_req), .o_enable(en), .o_role(role));
  twmh_slave slave_u (.i_scl(scl), .i_sda(sda), .i_ack(ack), .o_sda_oe(s_oe), .o_byte(sbyte));

  // The clock toggles every half period of 2.5 ns.
  initial forever #2.5 clk = ~clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    chk(8'(q.size()), 8'h00);
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic ctl(input logic [4:0] v);
    @(posedge clk);
    ctrl <= twmh_ctrl_type'(v);
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : ctl

  task automatic push(input logic [7:0] b);
    @(posedge clk);
    data <= b;
    dv <= 1'b1;
    @(posedge clk);
    dv <= 1'b0;
  endtask : push

  // Notes the expected code, waits for the flag, then checks the clock line is held.
  task automatic wdone(input logic [7:0] c);
    int n;
    n = 0;
    q.push_back(c);
    @(posedge clk);
    while (done !== 1'b1 && n < 30000)
    begin
      @(posedge clk);
      n++;
    end
    chk({7'h00, done}, 8'h01);
    repeat (50) @(posedge clk);
    chk({7'h00, scl}, 8'h00);
  endtask : wdone

  // One write transfer: start, address, then a data byte on ack or a repeated start on nack, then stop.
  task automatic xfer(input logic a);
    ack = a;
    push(8'h22);
    if (a) push(d);
    ctl(5'b10101);
    wdone(`TWMH_CODE_START);
    // A control write without the clear bit must leave the flag and the bus alone.
    ctl(5'h05);
    repeat (50) @(posedge clk);
    chk({7'h00, done}, 8'h01);
    ctl(5'b10001);
    wdone(a ? `TWMH_CODE_AW_ACK : `TWMH_CODE_AW_NACK);
    chk(sbyte, 8'h22);
    chk({5'h00, role}, {5'h00, ROLE_MASTER_TRANSMIT});
    // The next action is chosen from the masked status code.
    if ((status & 8'hF8) == `TWMH_CODE_AW_ACK)
    begin
      ctl(5'b10001);
      wdone(`TWMH_CODE_DW_ACK);
      chk(sbyte, d);
    end
    else
    begin
      ctl(5'h15);
      wdone(`TWMH_CODE_RSTART);
    end
    ctl(5'b10011);
    repeat (3000) @(posedge clk);
    chk({7'h00, done}, 8'h00);
    chk({7'h00, stop_req}, 8'h00);
    chk({6'h00, scl, sda}, 8'h03);
    chk({1'b0, rdy, scl_o, sda_o, en, role}, {5'h09, ROLE_NONE});
    chk(rxd, 8'h00);
    $display("test ack=%0d done", a);
  endtask : xfer

  // Each rising flag takes the oldest noted code and compares the status.
  always @(posedge clk)
  begin
    dq <= done;
    if (done === 1'b1 && dq === 1'b0)
      chk(status, q.size() ? q.pop_front() : 8'hFF);
  end

  // A hang is cut short after a fixed number of cycles.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      fails++;
      end_of_test();
    end
  end

  // Main sequence.
  initial
  begin
    void'($urandom(32'h507A1F6B));
    d = $urandom;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    xfer(1'b1);
    xfer(1'b0);
    end_of_test();
  end
endmodule : two_wire_mode_handshake_test

`default_nettype wire
